// ### acl_consts.vh
// Behaviour
// - double quote opens a string; closes at lone double quote; doubled quote is literal.
// - single quote opens a string; closes at lone single quote; doubled quote is literal.
// - quoted strings hold no CR or LF; an unterminated quoted string is an error.
// - unquoted string starts with a letter; then letters, digits or apostrophe.
// - other characters end a word; comma is a separator; unknown characters flag an error.
// - plus, minus, period or digit as first character starts a float number.
// - float is sign, integer digits, point, fraction digits, then E exponent.
// - hash-B header, digits 0 and 1, value 0 to 65535.
// - hash-Q header, digits 0 to 7, value up to 177777 octal.
// - hash-H header, hex digits either case, value up to FFFF.
// - invalid character inside a number is a format error; integers convert to float.
// - echo on returns errors at once; echo off holds them for the error queries.
// - every parsing or command error with a code below 200 sets event status bit 5.
// - every execution error sets event status bit 4.
// - number errors give 104 bad type, 106 missing digit, 107 unexpected digit.
// - codes 115 bad parameter, 116 syntax, 126 argument count are reported.
// - codes 201 out of range and 214 command too long are reported.
// - input buffer holds 1024 characters; overrun gives code 303.
// - output buffer holds 4096 characters; overrun gives code 304.
// - command moves to 2048-character parser buffer; no room gives code 305.
// - leaving remote mode while a response is sent gives code 301.
// - device errors set their status bit only and never enter the queue.
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define ACL_OFF_CTRL     8'h00
`define ACL_OFF_ESR      8'h04
`define ACL_OFF_ERR_CODE 8'h08
`define ACL_OFF_ERR_TEXT 8'h0C
`define ACL_OFF_STATUS   8'h10
`define ACL_RESP_OKAY    2'h0
`define ACL_RESP_SLVERR  2'h2
`define ACL_ESR_CMD      5
`define ACL_ESR_EXE      4
`define ACL_ESR_DEV      3

// ----------------------------------------
// error codes
// ----------------------------------------
`define ACL_E_NUM_TYPE   10'h068
`define ACL_E_DIG_EXP    10'h06A
`define ACL_E_DIG_NEXP   10'h06B
`define ACL_E_SYNTAX     10'h074
`define ACL_E_RANGE      10'h0C9
`define ACL_E_EXE_FIRST  10'h0C8
`define ACL_E_QUERY      10'h12D
`define ACL_E_IBUF       10'h12F
`define ACL_E_OBUF       10'h130
`define ACL_E_PBUF       10'h131

// ----------------------------------------
// buffer sizes and queue
// ----------------------------------------
`define ACL_IBUF_SIZE    11'h400
`define ACL_PBUF_SIZE    12'h800
`define ACL_OBUF_SIZE    13'h1000
`define ACL_QDEPTH       8

// ----------------------------------------
// characters and token kinds
// ----------------------------------------
`define ACL_CH_DQ        8'h22
`define ACL_CH_SQ        8'h27
`define ACL_CH_CR        8'h0D
`define ACL_CH_LF        8'h0A
`define ACL_CH_COMMA     8'h2C
`define ACL_CH_HASH      8'h23
`define ACL_CH_PLUS      8'h2B
`define ACL_CH_MINUS     8'h2D
`define ACL_CH_DOT       8'h2E
`define ACL_CH_SPACE     8'h20
`define ACL_CH_TAB       8'h09
`define ACL_CH_SEMI      8'h3B
`define ACL_CH_LC_E      8'h65
`define ACL_CH_LC_B      8'h62
`define ACL_CH_LC_Q      8'h71
`define ACL_CH_LC_H      8'h68
`define ACL_CASE_BIT     8'h20
`define ACL_TK_STR       2'h0
`define ACL_TK_FLT       2'h1
`define ACL_TK_INT       2'h2
`define ACL_RX_BIN       2'h1
`define ACL_RX_OCT       2'h2
`define ACL_RX_HEX       2'h3

`endif

// ### acl_lexer.v
`timescale 1ns/1ns
`include "acl_consts.vh"
module acl_lexer
(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [7:0]  rx_data,
	input  wire        rx_valid,
	output wire        rx_ready,
	output reg         tok_char_valid,
	output reg  [7:0]  tok_char,
	output reg  [1:0]  tok_char_kind,
	output reg         tok_end,
	output reg  [1:0]  tok_end_kind,
	output reg  [15:0] tok_int,
	output reg  [31:0] tok_float,
	output reg         sep_valid,
	output reg         cmd_end,
	output reg  [10:0] cmd_len_out,
	input  wire        cmd_done,
	input  wire [11:0] cmd_done_len,
	input  wire        resp_push,
	input  wire        resp_pop,
	input  wire        remote_exit,
	input  wire        tx_busy,
	input  wire        ext_err_valid,
	input  wire [9:0]  ext_err_code,
	input  wire        dev_err,
	output reg         err_out_valid,
	output reg  [9:0]  err_out_code
);

// ----------------------------------------
// states and helpers
// ----------------------------------------
localparam [9:0] S_IDLE = 10'h001;
localparam [9:0] S_DQ   = 10'h002;
localparam [9:0] S_DQE  = 10'h004;
localparam [9:0] S_SQ   = 10'h008;
localparam [9:0] S_SQE  = 10'h010;
localparam [9:0] S_WORD = 10'h020;
localparam [9:0] S_FLT  = 10'h040;
localparam [9:0] S_HASH = 10'h080;
localparam [9:0] S_BASE = 10'h100;
localparam [9:0] S_SKIP = 10'h200;
localparam [2:0] F_INT  = 3'h0;
localparam [2:0] F_FRAC = 3'h1;
localparam [2:0] F_EXP  = 3'h2;
localparam [2:0] F_EXPS = 3'h3;
localparam [2:0] F_EXPD = 3'h4;

function is_alpha;
	input [7:0] c;
	begin
		is_alpha = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
	end
endfunction

function is_digit;
	input [7:0] c;
	begin
		is_digit = (c >= 8'h30 && c <= 8'h39);
	end
endfunction

function is_delim;
	input [7:0] c;
	begin
		is_delim = c == `ACL_CH_SPACE || c == `ACL_CH_TAB || c == `ACL_CH_COMMA ||
			c == `ACL_CH_SEMI || c == `ACL_CH_CR || c == `ACL_CH_LF;
	end
endfunction

// bit 4 flags a hex digit, bits 3:0 carry its value
function [4:0] hex_val;
	input [7:0] c;
	reg   [7:0] lc;
	begin
		lc = c | `ACL_CASE_BIT;
		if (is_digit(c))
			hex_val = {1'b1, c[3:0]};
		else if (lc >= 8'h61 && lc <= 8'h66)
			hex_val = {1'b1, lc[3:0] + 4'h9};
		else
			hex_val = 5'h00;
	end
endfunction

function [31:0] u16_to_f32;
	input [15:0] v;
	integer      i;
	reg   [4:0]  msb;
	reg   [38:0] t;
	begin
		msb = 5'h00;
		for (i = 0; i < 16; i = i + 1)
			if (v[i])
				msb = i[4:0];
		t = {23'h000000, v} << (5'h17 - msb);
		if (v == 16'h0000)
			u16_to_f32 = 32'h00000000;
		else
			u16_to_f32 = {1'b0, 8'h7F + {3'h0, msb}, t[22:0]};
	end
endfunction

// ----------------------------------------
// lexer
// ----------------------------------------
reg  [9:0]  state;
reg  [2:0]  fph;
reg         has_digit;
reg  [16:0] acc;
reg  [1:0]  radix;
reg  [10:0] cmd_len;
reg         drop;
reg  [11:0] pused;
reg  [9:0]  next_state;
reg  [2:0]  next_fph;
reg         next_has;
reg  [16:0] next_acc;
reg  [1:0]  next_radix;
reg         tch_v;
reg  [1:0]  tch_kind;
reg         tend_v;
reg  [1:0]  tend_kind;
reg         lerr_v;
reg  [9:0]  lerr_code;
reg         sep_v;
reg         term_v;
reg         pass;
reg  [7:0]  q_ch;
reg  [4:0]  hv;
reg  [19:0] shifted;
reg         ovf;
wire        take  = rx_valid;
wire [7:0]  ch    = rx_data;
wire [7:0]  lch   = rx_data | `ACL_CASE_BIT;
wire        is_t  = (ch == `ACL_CH_CR) || (ch == `ACL_CH_LF);

// the lexer never stalls: every character is handled in its own cycle
assign rx_ready = 1'b1;

always @*
begin
	next_state = state;
	next_fph   = fph;
	next_has   = has_digit;
	next_acc   = acc;
	next_radix = radix;
	tch_v      = 1'b0;
	tch_kind   = `ACL_TK_STR;
	tend_v     = 1'b0;
	tend_kind  = `ACL_TK_STR;
	lerr_v     = 1'b0;
	lerr_code  = `ACL_E_SYNTAX;
	sep_v      = 1'b0;
	term_v     = 1'b0;
	pass       = 1'b0;
	q_ch       = (state == S_DQ || state == S_DQE) ? `ACL_CH_DQ : `ACL_CH_SQ;
	hv         = hex_val(ch);
	shifted    = 20'h00000;
	ovf        = acc[16];
	if (take)
	begin
		if (drop)
		begin
			if (is_t)
			begin
				term_v     = 1'b1;
				next_state = S_IDLE;
			end
		end
		else if (cmd_len == `ACL_IBUF_SIZE && !is_t)
		begin
			lerr_v     = 1'b1;
			lerr_code  = `ACL_E_IBUF;
			next_state = S_SKIP;
		end
		else
		begin
			case (state)
			S_DQ, S_SQ:
			begin
				if (ch == q_ch)
					next_state = (state == S_DQ) ? S_DQE : S_SQE;
				else if (is_t)
				begin
					lerr_v = 1'b1;
					pass   = 1'b1;
				end
				else
					tch_v = 1'b1;
			end
			S_DQE, S_SQE:
			begin
				if (ch == q_ch)
				begin
					tch_v      = 1'b1;
					next_state = (state == S_DQE) ? S_DQ : S_SQ;
				end
				else
				begin
					tend_v = 1'b1;
					pass   = 1'b1;
				end
			end
			S_WORD:
			begin
				if (is_alpha(ch) || is_digit(ch) || ch == `ACL_CH_SQ)
					tch_v = 1'b1;
				else
				begin
					tend_v = 1'b1;
					pass   = 1'b1;
				end
			end
			S_FLT:
			begin
				tch_kind = `ACL_TK_FLT;
				if (is_digit(ch))
				begin
					tch_v = 1'b1;
					if (fph == F_INT || fph == F_FRAC)
						next_has = 1'b1;
					else
						next_fph = F_EXPD;
				end
				else if (ch == `ACL_CH_DOT && fph == F_INT)
				begin
					tch_v    = 1'b1;
					next_fph = F_FRAC;
				end
				else if (lch == `ACL_CH_LC_E && (fph == F_INT || fph == F_FRAC))
				begin
					tch_v    = has_digit;
					next_fph = F_EXP;
					if (!has_digit)
					begin
						lerr_v     = 1'b1;
						lerr_code  = `ACL_E_DIG_EXP;
						next_state = S_SKIP;
					end
				end
				else if ((ch == `ACL_CH_PLUS || ch == `ACL_CH_MINUS) && fph == F_EXP)
				begin
					tch_v    = 1'b1;
					next_fph = F_EXPS;
				end
				else if (is_delim(ch))
				begin
					pass = 1'b1;
					if ((has_digit && fph != F_EXP && fph != F_EXPS))
					begin
						tend_v    = 1'b1;
						tend_kind = `ACL_TK_FLT;
					end
					else
					begin
						lerr_v    = 1'b1;
						lerr_code = `ACL_E_DIG_EXP;
					end
				end
				else
				begin
					lerr_v     = 1'b1;
					lerr_code  = `ACL_E_NUM_TYPE;
					next_state = S_SKIP;
				end
			end
			S_HASH:
			begin
				next_state = S_BASE;
				next_has   = 1'b0;
				next_acc   = 17'h00000;
				if (lch == `ACL_CH_LC_B)
					next_radix = `ACL_RX_BIN;
				else if (lch == `ACL_CH_LC_Q)
					next_radix = `ACL_RX_OCT;
				else if (lch == `ACL_CH_LC_H)
					next_radix = `ACL_RX_HEX;
				else
				begin
					lerr_v     = 1'b1;
					lerr_code  = `ACL_E_NUM_TYPE;
					next_state = S_SKIP;
				end
			end
			S_BASE:
			begin
				if (hv[4] && (radix == `ACL_RX_HEX ||
					(radix == `ACL_RX_OCT && hv[3:0] < 4'h8) || hv[3:1] == 3'h0))
				begin
					next_has = 1'b1;
					case (radix)
					`ACL_RX_BIN:
					begin
						shifted = {3'h0, acc[15:0], 1'b0} | {16'h0000, hv[3:0]};
						ovf     = ovf | acc[15];
					end
					`ACL_RX_OCT:
					begin
						shifted = {1'b0, acc[15:0], 3'h0} | {16'h0000, hv[3:0]};
						ovf     = ovf | (acc[15:13] != 3'h0);
					end
					default:
					begin
						shifted = {acc[15:0], hv[3:0]};
						ovf     = ovf | (acc[15:12] != 4'h0);
					end
					endcase
					next_acc = {ovf, shifted[15:0]};
				end
				else if (is_delim(ch))
				begin
					pass = 1'b1;
					if (!has_digit)
					begin
						lerr_v    = 1'b1;
						lerr_code = `ACL_E_DIG_EXP;
					end
					else if (acc[16])
					begin
						lerr_v    = 1'b1;
						lerr_code = `ACL_E_RANGE;
					end
					else
					begin
						tend_v    = 1'b1;
						tend_kind = `ACL_TK_INT;
					end
				end
				else
				begin
					lerr_v     = 1'b1;
					lerr_code  = hv[4] ? `ACL_E_DIG_NEXP : `ACL_E_NUM_TYPE;
					next_state = S_SKIP;
				end
			end
			S_SKIP:
				pass = is_delim(ch);
			default:
				pass = 1'b1;
			endcase
			if (pass)
			begin
				next_state = S_IDLE;
				if (ch == `ACL_CH_DQ)
					next_state = S_DQ;
				else if (ch == `ACL_CH_SQ)
					next_state = S_SQ;
				else if (is_alpha(ch))
				begin
					tch_v      = 1'b1;
					tch_kind   = `ACL_TK_STR;
					next_state = S_WORD;
				end
				else if (is_digit(ch) || ch == `ACL_CH_PLUS || ch == `ACL_CH_MINUS ||
					ch == `ACL_CH_DOT)
				begin
					tch_v      = 1'b1;
					tch_kind   = `ACL_TK_FLT;
					next_state = S_FLT;
					next_fph   = (ch == `ACL_CH_DOT) ? F_FRAC : F_INT;
					next_has   = is_digit(ch);
				end
				else if (ch == `ACL_CH_HASH)
					next_state = S_HASH;
				else if (ch == `ACL_CH_COMMA)
					sep_v = 1'b1;
				else if (is_t)
					term_v = 1'b1;
				else if (!is_delim(ch) && !lerr_v)
				begin
					lerr_v    = 1'b1;
					lerr_code = `ACL_E_SYNTAX;
				end
			end
		end
	end
end

// ----------------------------------------
// buffers, error sources and queue
// ----------------------------------------
reg  [12:0] olevel;
reg  [7:0]  esr;
reg         echo;
reg  [9:0]  errq [0:`ACL_QDEPTH-1];
reg  [2:0]  q_wr;
reg  [2:0]  q_rd;
reg  [3:0]  q_cnt;
reg         e_v;
reg  [9:0]  e_code;
reg         set_cmd;
reg         set_exe;
wire        pbuf_err = take && term_v && !drop &&
	({1'b0, cmd_len} > (`ACL_PBUF_SIZE - pused));
wire        obuf_err = resp_push && !resp_pop && olevel == `ACL_OBUF_SIZE;
wire        qry_err  = remote_exit && tx_busy;
wire        q_pop;
wire        q_push   = e_v && !echo && q_cnt != `ACL_QDEPTH;

always @*
begin
	e_v    = 1'b1;
	e_code = lerr_code;
	if (lerr_v)
		e_code = lerr_code;
	else if (pbuf_err)
		e_code = `ACL_E_PBUF;
	else if (obuf_err)
		e_code = `ACL_E_OBUF;
	else if (qry_err)
		e_code = `ACL_E_QUERY;
	else if (ext_err_valid)
		e_code = ext_err_code;
	else
		e_v = 1'b0;
	set_cmd = (lerr_v && lerr_code < `ACL_E_EXE_FIRST) ||
		(ext_err_valid && ext_err_code < `ACL_E_EXE_FIRST);
	set_exe = (lerr_v && lerr_code >= `ACL_E_EXE_FIRST) || pbuf_err || obuf_err ||
		qry_err || (ext_err_valid && ext_err_code >= `ACL_E_EXE_FIRST);
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state <= S_IDLE;
		fph <= F_INT;
		has_digit <= 1'b0;
		acc <= 17'h00000;
		radix <= `ACL_RX_BIN;
		cmd_len <= 11'h000;
		drop <= 1'b0;
		pused <= 12'h000;
		olevel <= 13'h0000;
		q_wr <= 3'h0;
		q_cnt <= 4'h0;
		q_rd <= 3'h0;
		tok_char_valid <= 1'b0;
		tok_char <= 8'h00;
		tok_char_kind <= `ACL_TK_STR;
		tok_end <= 1'b0;
		tok_end_kind <= `ACL_TK_STR;
		tok_int <= 16'h0000;
		tok_float <= 32'h00000000;
		sep_valid <= 1'b0;
		cmd_end <= 1'b0;
		cmd_len_out <= 11'h000;
		err_out_valid <= 1'b0;
		err_out_code <= 10'h000;
	end
	else
	begin
		state <= next_state;
		fph <= next_fph;
		has_digit <= next_has;
		acc <= next_acc;
		radix <= next_radix;
		tok_char_valid <= tch_v;
		tok_char <= ch;
		tok_char_kind <= tch_kind;
		tok_end <= tend_v;
		tok_end_kind <= tend_kind;
		tok_int <= acc[15:0];
		tok_float <= u16_to_f32(acc[15:0]);
		sep_valid <= sep_v;
		cmd_end <= term_v;
		if (term_v)
			cmd_len_out <= cmd_len;
		if (take && term_v)
			cmd_len <= 11'h000;
		else if (take && cmd_len != `ACL_IBUF_SIZE)
			cmd_len <= cmd_len + 11'h001;
		if (take && term_v)
			drop <= 1'b0;
		else if (lerr_v && lerr_code == `ACL_E_IBUF)
			drop <= 1'b1;
		// an overrun command is discarded, so it never claims parser space
		pused <= pused + ((term_v && !drop && !pbuf_err) ? {1'b0, cmd_len} : 12'h000) -
			(cmd_done ? cmd_done_len : 12'h000);
		if (resp_push && !resp_pop && olevel != `ACL_OBUF_SIZE)
			olevel <= olevel + 13'h0001;
		else if (resp_pop && !resp_push && olevel != 13'h0000)
			olevel <= olevel - 13'h0001;
		err_out_valid <= e_v && echo;
		err_out_code <= e_code;
		if (q_push)
		begin
			errq[q_wr] <= e_code;
			q_wr <= q_wr + 3'h1;
		end
		if (q_pop)
			q_rd <= q_rd + 3'h1;
		q_cnt <= q_cnt + {3'h0, q_push} - {3'h0, q_pop};
	end
end

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
reg         aw_held;
reg         w_held;
reg  [7:0]  aw_addr;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
wire [7:0]  ar_word = {s_axi_araddr[7:2], 2'h0};
wire [7:0]  aw_word = {aw_addr[7:2], 2'h0};
wire        rd_take = s_axi_arvalid && !s_axi_rvalid;
wire        wr_go   = aw_held && w_held && !s_axi_bvalid;
wire        rd_esr  = rd_take && ar_word == `ACL_OFF_ESR;

// reading either error register pops the oldest entry; text is formed by software
assign q_pop = rd_take && q_cnt != 4'h0 &&
	(ar_word == `ACL_OFF_ERR_CODE || ar_word == `ACL_OFF_ERR_TEXT);
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready  = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `ACL_RESP_OKAY;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= `ACL_RESP_OKAY;
		s_axi_rdata <= 32'h00000000;
		echo <= 1'b0;
		esr <= 8'h00;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (wr_go)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `ACL_RESP_OKAY;
			if (aw_word == `ACL_OFF_CTRL)
			begin
				if (w_strb[0])
					echo <= w_data[0];
			end
			else if (aw_word != `ACL_OFF_ESR && aw_word != `ACL_OFF_ERR_CODE &&
				aw_word != `ACL_OFF_ERR_TEXT && aw_word != `ACL_OFF_STATUS)
				s_axi_bresp <= `ACL_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (rd_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ACL_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			if (ar_word == `ACL_OFF_CTRL)
				s_axi_rdata <= {31'h00000000, echo};
			else if (ar_word == `ACL_OFF_ESR)
				s_axi_rdata <= {24'h000000, esr};
			else if (ar_word == `ACL_OFF_ERR_CODE || ar_word == `ACL_OFF_ERR_TEXT)
				s_axi_rdata <= (q_cnt != 4'h0) ? {22'h000000, errq[q_rd]} : 32'h00000000;
			else if (ar_word == `ACL_OFF_STATUS)
				s_axi_rdata <= {3'h0, olevel, pused, q_cnt};
			else
				s_axi_rresp <= `ACL_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		// a read clears the byte, but an event in the same cycle survives
		esr <= (rd_esr ? 8'h00 : esr) |
			({7'h00, set_cmd} << `ACL_ESR_CMD) |
			({7'h00, set_exe} << `ACL_ESR_EXE) |
			({7'h00, dev_err} << `ACL_ESR_DEV);
	end
end

endmodule

// ### acl_host_model.sv
`timescale 1ns/1ns
module acl_host_model
(
	input  wire  logic       aclk,
	output logic       [7:0] rx_data,
	output logic             rx_valid
);
	initial
	begin
		rx_data = 8'hFF;
		rx_valid = 1'b0;
	end
	// host keeps CR and LF out of quoted strings except to test the error
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge aclk);
			rx_data <= s[i];
			rx_valid <= 1'b1;
		end
		@(posedge aclk);
		// idle line shows the inverse so a stale character never looks valid
		rx_data <= ~rx_data;
		rx_valid <= 1'b0;
	endtask
endmodule

// ### acl_lexer_asserts.sv
`timescale 1ns/1ns
`include "acl_consts.vh"
module acl_lexer_chk
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        tok_char_valid,
	input wire logic        sep_valid,
	input wire logic        cmd_end,
	input wire logic        tok_end,
	input wire logic [1:0]  tok_end_kind,
	input wire logic [15:0] tok_int,
	input wire logic [31:0] tok_float
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------
	// properties
	// ----------------
	property p_wr_lock;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_lock: assert property (p_wr_lock) else $error("write taken during response");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_sep;
		sep_valid |-> $past(rx_valid) && $past(rx_data) == `ACL_CH_COMMA;
	endproperty
	a_sep: assert property (p_sep) else $error("separator without comma");
	property p_cmd;
		cmd_end |-> $past(rx_valid) && ($past(rx_data) == `ACL_CH_CR || $past(rx_data) == `ACL_CH_LF);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command end without terminator");
	property p_flt;
		tok_end && tok_end_kind == `ACL_TK_INT |-> !tok_float[31] && (tok_int == 16'h0000) == (tok_float == 32'h00000000);
	endproperty
	a_flt: assert property (p_flt) else $error("integer float mismatch");
	property p_char_src;
		tok_char_valid |-> $past(rx_valid);
	endproperty
	a_char_src: assert property (p_char_src) else $error("token char without input");
endmodule
bind acl_lexer acl_lexer_chk u_chk (.*);

// ### ascii_command_lexer_errors_bench.sv
`timescale 1ns/1ns
`include "acl_consts.vh"
module ascii_command_lexer_errors_bench;
	logic        aclk, aresetn, ch_on, tk_on;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tok_char;
	logic [31:0] s_axi_wdata, s_axi_rdata, tok_float;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tok_char_kind, tok_end_kind;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        rx_valid, rx_ready, tok_char_valid, tok_end, sep_valid, cmd_end, cmd_done;
	logic        resp_push, resp_pop, remote_exit, tx_busy, ext_err_valid, dev_err, err_out_valid;
	logic [15:0] tok_int, v;
	logic [10:0] cmd_len_out;
	logic [11:0] cmd_done_len;
	logic [9:0]  err_out_code, ext_err_code;
	logic [35:0] q[$];
	int          mismatches, n_tests, cyc;
	string       s, tb[6];
	logic [9:0]  tc[6];
	acl_lexer dut (.*);
	acl_host_model host (.aclk(aclk), .rx_data(rx_data), .rx_valid(rx_valid));
	always #2 aclk = ~aclk;
	// ----------------
	// helpers
	// ----------------
	task automatic report_and_stop;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [35:0] g, input logic [35:0] e);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [3:0] k, input logic [31:0] g);
		if (q.size() == 0)
			cmp({k, g}, 36'hF00000000);
		else
			cmp({k, g}, q.pop_front());
	endtask
	task automatic ex(input logic [3:0] k, input logic [31:0] x);
		q.push_back({k, x});
	endtask
	task automatic exs(input string t, input logic [1:0] k);
		for (int i = 0; i < t.len(); i++)
			ex(4'h1, {22'h0, k, t[i]});
	endtask
	function automatic logic [31:0] f2(input logic [15:0] x);
		int p;
		p = 15;
		if (x == 16'h0000)
			return 32'h00000000;
		while (!x[p])
			p--;
		return {1'b0, 8'(127 + p), 23'(x) << (23 - p)};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
		cmp(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			done = s_axi_rvalid;
		end
		s_axi_rready <= 1'b0;
		cmp({s_axi_rresp, s_axi_rdata}, {er, e});
	endtask
	task automatic drain(input string n);
		repeat (4) @(posedge aclk);
		cmp(q.size(), 0);
		$display("test %s done", n);
	endtask
	task automatic poke(input logic [9:0] c, input logic rx);
		@(posedge aclk);
		{ext_err_valid, ext_err_code, remote_exit, tx_busy} <= {!rx, c, rx, rx};
		@(posedge aclk);
		{ext_err_valid, remote_exit, tx_busy} <= 3'h0;
	endtask
	// ----------------
	// monitor and timeout
	// ----------------
	always @(posedge aclk)
	begin
		if (aresetn && tk_on && tok_end)
		begin
			chk(4'h2, 32'(tok_end_kind));
			if (tok_end_kind === `ACL_TK_INT)
			begin
				chk(4'h6, 32'(tok_int));
				chk(4'h7, tok_float);
			end
		end
		if (aresetn && tk_on && sep_valid)
			chk(4'h3, 32'h0);
		if (aresetn && ch_on && tok_char_valid)
			chk(4'h1, {22'h0, tok_char_kind, tok_char});
		if (aresetn && tk_on && cmd_end)
			chk(4'h4, 32'(cmd_len_out));
		if (aresetn && err_out_valid)
			chk(4'h5, 32'(err_out_code));
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	// ----------------
	// tests
	// ----------------
	initial
	begin
		aclk = 1'b0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, cmd_done, cmd_done_len, resp_push} = '0;
		{resp_pop, remote_exit, tx_busy, ext_err_valid, ext_err_code, dev_err} = '0;
		{s_axi_wstrb, ch_on, tk_on} = 6'h3F;
		v = 16'($urandom(49));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ACL_OFF_CTRL, 0, `ACL_RESP_OKAY);
		wr(`ACL_OFF_ESR, 32'hFF, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ESR, 0, `ACL_RESP_OKAY);
		wr(8'h40, 1, `ACL_RESP_SLVERR);
		rd(8'h40, 0, `ACL_RESP_SLVERR);
		drain("regs");
		exs("b'2", `ACL_TK_STR);
		ex(4'h2, `ACL_TK_STR);
		ex(4'h3, 0);
		exs("-1.2e+0", `ACL_TK_FLT);
		ex(4'h2, `ACL_TK_FLT);
		ex(4'h4, 11);
		host.send("b'2,-1.2e+0\n");
		foreach (tb[i])
		begin
			s = $sformatf("%ca%c%cb%c\n", i[0] ? 8'h27 : 8'h22, i[0] ? 8'h27 : 8'h22,
				i[0] ? 8'h27 : 8'h22, i[0] ? 8'h27 : 8'h22);
			exs({"a", s.substr(0, 0), "b"}, `ACL_TK_STR);
			ex(4'h2, `ACL_TK_STR);
			ex(4'h4, i ? 13 : 6);
			host.send(s);
			v = (i == 5) ? 16'hFFFF : 16'($urandom);
			ex(4'h2, `ACL_TK_INT);
			ex(4'h6, v);
			ex(4'h7, f2(v));
			host.send($sformatf("#%s%h ", i[0] ? "h" : "H", v));
		end
		ch_on = 1'b0;
		tb = '{"#B10000001 ", "#b010000001 ", "#Q201 ", "#q0201 ", "#H7F ", "#h007f "};
		foreach (tb[i])
		begin
			v = (i > 3) ? 16'd127 : 16'd129;
			ex(4'h2, `ACL_TK_INT);
			ex(4'h6, v);
			ex(4'h7, f2(v));
			host.send(tb[i]);
		end
		drain("tokens");
		tk_on = 1'b0;
		host.send("w/cm\n#Z \n#H10000\n");
		rd(`ACL_OFF_ERR_CODE, `ACL_E_SYNTAX, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ERR_TEXT, `ACL_E_NUM_TYPE, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ERR_CODE, `ACL_E_RANGE, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ERR_CODE, 0, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ESR, 32'h30, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ESR, 0, `ACL_RESP_OKAY);
		drain("queue");
		wr(`ACL_OFF_CTRL, 1, `ACL_RESP_OKAY);
		tb = '{"\"ab\n", "w/cm\n", "#Z \n", "+ \n", "#B12 \n", "#Q200000 \n"};
		tc = '{10'h074, 10'h074, 10'h068, 10'h06A, 10'h06B, 10'h0C9};
		foreach (tb[i])
		begin
			ex(4'h5, tc[i]);
			host.send(tb[i]);
		end
		ex(4'h5, 10'd126);
		poke(10'd126, 1'b0);
		ex(4'h5, 10'd214);
		poke(10'd214, 1'b0);
		ex(4'h5, `ACL_E_QUERY);
		poke(10'd0, 1'b1);
		drain("echo");
		rd(`ACL_OFF_ESR, 32'h30, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ERR_CODE, 0, `ACL_RESP_OKAY);
		@(posedge aclk);
		dev_err <= 1'b1;
		@(posedge aclk);
		dev_err <= 1'b0;
		drain("device");
		rd(`ACL_OFF_ESR, 32'h08, `ACL_RESP_OKAY);
		rd(`ACL_OFF_ERR_CODE, 0, `ACL_RESP_OKAY);
		s = "a";
		repeat (1024) s = {s, "a"};
		ex(4'h5, `ACL_E_IBUF);
		host.send({s, "\n"});
		ex(4'h5, `ACL_E_PBUF);
		host.send({s.substr(0, 999), "\n", s.substr(0, 999), "\n"});
		ex(4'h5, `ACL_E_OBUF);
		resp_push <= 1'b1;
		repeat (4097) @(posedge aclk);
		resp_push <= 1'b0;
		drain("buffers");
		report_and_stop();
	end
endmodule
